// File: external_pin_interrupt_unit.v
// External pin and pin-change interrupt unit with its register port
`timescale 1ns/1ps
`default_nettype none
`include "ext_int_defines.vh"

module external_pin_interrupt_unit
(
	input wire clk_in,
	input wire reset_n_in,
	input wire [7:0] addr_in,
	input wire io_space_in,
	input wire write_en_in,
	input wire read_en_in,
	input wire [7:0] write_data_in,
	input wire global_enable_in,
	input wire line_zero_ack_in,
	input wire line_one_ack_in,
	input wire [2:0] group_ack_in,
	input wire external_line_zero_in,
	input wire external_line_one_in,
	input wire [23:0] pin_change_line_in,
	output reg [7:0] read_data_out,
	output reg line_zero_request_out,
	output reg line_one_request_out,
	output reg group0_request_out,
	output reg group1_request_out,
	output reg group2_request_out,
	output reg wake_out
);

////////////////////////////////////////////////////////////////////////
// Helpers

// I/O instructions see the low window shifted down
function [7:0] map_addr;
	input [7:0] a;
	input io;
	begin
		map_addr = io ? a + `IO_OFFSET : a;
	end
endfunction

// Edge-type match for one dedicated line; level mode never matches here
function line_event;
	input [1:0] mode;
	input cur;
	input prev;
	begin
		case (mode)
			`SENSE_ANY: line_event = cur ^ prev;
			`SENSE_FALL: line_event = prev & ~cur;
			`SENSE_RISE: line_event = cur & ~prev;
			default: line_event = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Synchronised inputs

wire [`PIN_COUNT-1:0] pins_now;
wire [`PIN_COUNT-1:0] pins_prev;

// Stages reset low: a line high at release looks like a rise
// Pin direction is not looked at, so output-driven pins still trigger
pin_sync #(.WIDTH(`PIN_COUNT)) u_sync
(
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.pins_in({external_line_one_in, external_line_zero_in, pin_change_line_in}),
	.now_out(pins_now),
	.prev_out(pins_prev)
);

wire [1:0] line_now = pins_now[25:24];
wire [1:0] line_prev = pins_prev[25:24];
wire [23:0] pc_now = pins_now[23:0];
wire [23:0] pc_prev = pins_prev[23:0];

////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] sense_control_reg;
reg [7:0] line_enables_reg;
reg [7:0] line_flags_reg;
reg [7:0] group_enables_reg;
reg [7:0] group_flags_reg;
reg [7:0] mask_group0_reg;
reg [7:0] mask_group1_reg;
reg [7:0] mask_group2_reg;

reg [7:0] line_flags_next;
reg [7:0] group_flags_next;
reg [7:0] read_data_next;

// Address decode
wire [7:0] eff_addr = map_addr(addr_in, io_space_in);
// Extended registers at 0x60 and up are reachable only from data space
wire access_ok = !io_space_in || (addr_in < `IO_LIMIT);
wire wr = write_en_in && access_ok;
wire rd = read_en_in && access_ok;

wire hit_group_flags = (eff_addr == `ADDR_GROUP_FLAGS);
wire hit_line_flags = (eff_addr == `ADDR_LINE_FLAGS);
wire hit_line_enables = (eff_addr == `ADDR_LINE_ENABLES);
wire hit_group_enables = (eff_addr == `ADDR_GROUP_ENABLES);
wire hit_sense = (eff_addr == `ADDR_SENSE_CONTROL);
wire hit_mask0 = (eff_addr == `ADDR_MASK_GROUP0);
wire hit_mask1 = (eff_addr == `ADDR_MASK_GROUP1);
wire hit_mask2 = (eff_addr == `ADDR_MASK_GROUP2);

////////////////////////////////////////////////////////////////////////
// Dedicated line detection

wire [1:0] sense0 = sense_control_reg[`LINE0_SENSE_MSB:`LINE0_SENSE_LSB];
wire [1:0] sense1 = sense_control_reg[`LINE1_SENSE_MSB:`LINE1_SENSE_LSB];
wire [1:0] level_mode;
wire [1:0] line_set;
wire [1:0] line_clr;
wire [1:0] level_active;

assign level_mode[0] = (sense0 == `SENSE_LOW);
assign level_mode[1] = (sense1 == `SENSE_LOW);

// A pulse longer than one clock shows up in two successive samples
assign line_set[0] = line_event(sense0, line_now[0], line_prev[0]);
assign line_set[1] = line_event(sense1, line_now[1], line_prev[1]);

// Vector entry or a one written clears; a zero written leaves the flag
assign line_clr[0] = line_zero_ack_in || (wr && hit_line_flags && write_data_in[0]);
assign line_clr[1] = line_one_ack_in || (wr && hit_line_flags && write_data_in[1]);

// Low level is seen while the line sits low, no edge involved
assign level_active = level_mode & ~line_now;

always @*
begin
	line_flags_next = `REG_RESET;
	// Set beats clear so an edge in the clearing cycle survives
	line_flags_next[1:0] = (line_flags_reg[1:0] & ~line_clr) | line_set;
	// Level mode keeps the flag cleared
	line_flags_next[1:0] = line_flags_next[1:0] & ~level_mode;
end

////////////////////////////////////////////////////////////////////////
// Pin-change group detection

wire [23:0] pc_toggle = pc_now ^ pc_prev;
wire [7:0] g0_lines = pc_toggle[`GROUP0_MSB:`GROUP0_LSB] & mask_group0_reg;
// Line 15 has no mask bit, so group one sees only 14:8
wire [7:0] g1_lines = pc_toggle[`GROUP1_MSB:`GROUP1_LSB] & mask_group1_reg;
wire [7:0] g2_lines = pc_toggle[`GROUP2_MSB:`GROUP2_LSB] & mask_group2_reg;
wire [2:0] group_set;
wire [2:0] group_clr;

// A line counts only with its mask bit and its group enable
assign group_set[0] = (|g0_lines) && group_enables_reg[0];
assign group_set[1] = (|g1_lines) && group_enables_reg[1];
assign group_set[2] = (|g2_lines) && group_enables_reg[2];

// Vector entry and a one written both clear; set still wins below
assign group_clr = group_ack_in | ({3{wr && hit_group_flags}} & write_data_in[2:0]);

always @*
begin
	group_flags_next = `REG_RESET;
	group_flags_next[2:0] = (group_flags_reg[2:0] & ~group_clr) | group_set;
end

////////////////////////////////////////////////////////////////////////
// Read data

// Refused, unmapped or idle reads return zero
always @*
begin
	read_data_next = `REG_RESET;
	if (rd)
	begin
		case (eff_addr)
			`ADDR_GROUP_FLAGS: read_data_next = group_flags_reg;
			// Mode just switched to level: hide the stale flag
			`ADDR_LINE_FLAGS: read_data_next = line_flags_reg & ~{6'h00, level_mode};
			`ADDR_LINE_ENABLES: read_data_next = line_enables_reg;
			`ADDR_GROUP_ENABLES: read_data_next = group_enables_reg;
			`ADDR_SENSE_CONTROL: read_data_next = sense_control_reg;
			`ADDR_MASK_GROUP0: read_data_next = mask_group0_reg;
			`ADDR_MASK_GROUP1: read_data_next = mask_group1_reg;
			`ADDR_MASK_GROUP2: read_data_next = mask_group2_reg;
			default: read_data_next = `REG_RESET;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		sense_control_reg <= `REG_RESET;
		line_enables_reg <= `REG_RESET;
		group_enables_reg <= `REG_RESET;
		mask_group0_reg <= `REG_RESET;
		mask_group1_reg <= `REG_RESET;
		mask_group2_reg <= `REG_RESET;
		line_flags_reg <= `REG_RESET;
		group_flags_reg <= `REG_RESET;
		read_data_out <= `REG_RESET;
	end
	else
	begin
		if (wr && hit_sense)
		begin
			sense_control_reg <= write_data_in & `SENSE_BITS;
		end
		if (wr && hit_line_enables)
		begin
			line_enables_reg <= write_data_in & `LINE_BITS;
		end
		if (wr && hit_group_enables)
		begin
			group_enables_reg <= write_data_in & `GROUP_BITS;
		end
		if (wr && hit_mask0)
		begin
			mask_group0_reg <= write_data_in;
		end
		if (wr && hit_mask1)
		begin
			mask_group1_reg <= write_data_in & `MASK1_BITS;
		end
		if (wr && hit_mask2)
		begin
			mask_group2_reg <= write_data_in;
		end
		line_flags_reg <= line_flags_next;
		group_flags_reg <= group_flags_next;
		read_data_out <= read_data_next;
	end
end

////////////////////////////////////////////////////////////////////////
// Requests to the core and wake

always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		line_zero_request_out <= 1'b0;
		line_one_request_out <= 1'b0;
		group0_request_out <= 1'b0;
		group1_request_out <= 1'b0;
		group2_request_out <= 1'b0;
		wake_out <= 1'b0;
	end
	else
	begin
		// Taken from next-flag so flag and request rise on one edge
		// Level mode drives the request from the line, edge modes from the flag
		line_zero_request_out <= global_enable_in && line_enables_reg[0] &&
			(level_active[0] || line_flags_next[0]);
		line_one_request_out <= global_enable_in && line_enables_reg[1] &&
			(level_active[1] || line_flags_next[1]);
		group0_request_out <= global_enable_in && group_enables_reg[0] &&
			group_flags_next[0];
		group1_request_out <= global_enable_in && group_enables_reg[1] &&
			group_flags_next[1];
		group2_request_out <= global_enable_in && group_enables_reg[2] &&
			group_flags_next[2];
		// Wake ignores the global enable; only the local enables matter.
		// Limitation: still sampled, so a truly stopped clock needs a pad latch.
		wake_out <= (|group_set) || (|(level_active & line_enables_reg[1:0]));
	end
end

endmodule

`default_nettype wire

// File: ext_int_defines.vh
// Constants for the external pin interrupt unit
`ifndef EXT_INT_DEFINES_VH
`define EXT_INT_DEFINES_VH

// Data-space register addresses
`define ADDR_GROUP_FLAGS 8'h3b
`define ADDR_LINE_FLAGS 8'h3c
`define ADDR_LINE_ENABLES 8'h3d
`define ADDR_GROUP_ENABLES 8'h68
`define ADDR_SENSE_CONTROL 8'h69
`define ADDR_MASK_GROUP0 8'h6b
`define ADDR_MASK_GROUP1 8'h6c
`define ADDR_MASK_GROUP2 8'h6d

// I/O-instruction window
`define IO_OFFSET 8'h20
`define IO_LIMIT 8'h40

// Writable bit masks and register reset value
`define SENSE_BITS 8'h0f
`define LINE_BITS 8'h03
`define GROUP_BITS 8'h07
`define MASK1_BITS 8'h7f
`define REG_RESET 8'h00

// Sense field positions
`define LINE0_SENSE_LSB 0
`define LINE0_SENSE_MSB 1
`define LINE1_SENSE_LSB 2
`define LINE1_SENSE_MSB 3

// Sense field codes
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

// Pin-change group slices
`define GROUP0_LSB 0
`define GROUP0_MSB 7
`define GROUP1_LSB 8
`define GROUP1_MSB 15
`define GROUP2_LSB 16
`define GROUP2_MSB 23

// Input vector width: two dedicated lines plus 24 change lines
`define PIN_COUNT 26

`endif

// File: pin_sync.v
// Two-stage synchroniser with one extra history stage for edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
	parameter WIDTH = 26
)
(
	input wire clk_in,
	input wire reset_n_in,
	input wire [WIDTH-1:0] pins_in,
	output wire [WIDTH-1:0] now_out,
	output wire [WIDTH-1:0] prev_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;
reg [WIDTH-1:0] hist_reg;

// Stage one is read only by stage two; the history stage feeds edge logic
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		meta_reg <= {WIDTH{1'b0}};
		sync_reg <= {WIDTH{1'b0}};
		hist_reg <= {WIDTH{1'b0}};
	end
	else
	begin
		meta_reg <= pins_in;
		sync_reg <= meta_reg;
		hist_reg <= sync_reg;
	end
end

assign now_out = sync_reg;
assign prev_out = hist_reg;

endmodule

`default_nettype wire

// File: ext_pin_source.sv
// Far-side model driving the dedicated and pin-change lines
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source
(
	input wire logic clk_in,
	input wire logic [25:0] level_in,
	output logic [25:0] pins_out
);
	initial pins_out = 26'h000_0000;
	// Change only on falling edges, so every pulse lasts whole cycles
	// A low level is held for many cycles, past any instruction end
	always @(negedge clk_in)
	begin
		pins_out <= level_in;
	end
endmodule
`default_nettype wire

// File: ext_int_properties.sv
// Port assertions for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module ext_int_checker
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] addr_in,
	input wire logic io_space_in,
	input wire logic read_en_in,
	input wire logic global_enable_in,
	input wire logic [7:0] read_data_out,
	input wire logic line_zero_request_out,
	input wire logic line_one_request_out,
	input wire logic group0_request_out,
	input wire logic group1_request_out,
	input wire logic group2_request_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////////
	line0_gated_a: assert property (line_zero_request_out |-> $past(global_enable_in))
		else $error("line zero request without global enable");
	line1_gated_a: assert property (line_one_request_out |-> $past(global_enable_in))
		else $error("line one request without global enable");
	group_gated_a: assert property ((group0_request_out || group1_request_out
		|| group2_request_out) |-> $past(global_enable_in))
		else $error("group request without global enable");
	io_refused_a: assert property (read_en_in && io_space_in && addr_in >= 8'h40
		|=> read_data_out == 8'h00)
		else $error("io read above window answered");
	idle_read_a: assert property (!read_en_in |=> read_data_out == 8'h00)
		else $error("read data without read");
	lflag_bits_a: assert property (read_en_in && !io_space_in && addr_in == 8'h3c
		|=> read_data_out[7:2] == 6'h00)
		else $error("line flag spare bits set");
	gflag_bits_a: assert property (read_en_in && !io_space_in && addr_in == 8'h3b
		|=> read_data_out[7:3] == 5'h00)
		else $error("group flag spare bits set");
	sense_bits_a: assert property (read_en_in && !io_space_in && addr_in == 8'h69
		|=> read_data_out[7:4] == 4'h0)
		else $error("sense spare bits set");
endmodule
bind external_pin_interrupt_unit ext_int_checker chk_u(.clk_in(clk_in), .reset_n_in(reset_n_in),
	.addr_in(addr_in), .io_space_in(io_space_in), .read_en_in(read_en_in),
	.global_enable_in(global_enable_in), .read_data_out(read_data_out),
	.line_zero_request_out(line_zero_request_out), .line_one_request_out(line_one_request_out),
	.group0_request_out(group0_request_out), .group1_request_out(group1_request_out),
	.group2_request_out(group2_request_out));
`default_nettype wire

// File: external_pin_interrupt_unit_tb.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "ext_int_defines.vh"
module external_pin_interrupt_unit_tb;
	logic clk_in = 0, rst_n = 0, io = 0, we = 0, re = 0, gie = 0, e;
	logic [7:0] addr = 0, wd = 0, rdv, d, ra[6], rm[6];
	logic [1:0] lack = 0;
	logic [2:0] gack = 0, ge, ef;
	logic [25:0] lvl = 0;
	logic [23:0] mk;
	wire [25:0] pins;
	wire [7:0] rdata;
	wire [4:0] req;
	wire wake;
	int num_errors = 0, n_checks = 0, cyc = 0, i, l, m, k, wake_cnt = 0, wc;
	always #12.5 clk_in = ~clk_in;
	ext_pin_source src_u(.clk_in(clk_in), .level_in(lvl), .pins_out(pins));
	external_pin_interrupt_unit dut_u(.clk_in(clk_in), .reset_n_in(rst_n), .addr_in(addr),
		.io_space_in(io), .write_en_in(we), .read_en_in(re), .write_data_in(wd),
		.global_enable_in(gie), .line_zero_ack_in(lack[0]), .line_one_ack_in(lack[1]),
		.group_ack_in(gack), .external_line_zero_in(pins[0]), .external_line_one_in(pins[1]),
		.pin_change_line_in(pins[25:2]), .read_data_out(rdata),
		.line_zero_request_out(req[0]), .line_one_request_out(req[1]),
		.group0_request_out(req[2]), .group1_request_out(req[3]),
		.group2_request_out(req[4]), .wake_out(wake));
	////////////////////////////////////////////////////////////////
	function automatic logic hit(input [1:0] s, input o, input n);
		return s == 0 ? !n : s == 1 ? o != n : s == 2 ? o & !n : !o & n;
	endfunction
	// Bit 15 has no mask, so it belongs to no group
	function automatic int grp(input int p);
		return p < 8 ? 0 : p < 15 ? 1 : p == 15 ? 3 : 2;
	endfunction
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
		n_checks++;
		if (x !== y)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic bus(input [7:0] a, input s, input w, input [7:0] v);
		@(negedge clk_in);
		addr <= a;
		io <= s;
		we <= w;
		re <= !w;
		wd <= v;
		@(negedge clk_in);
		rdv = rdata;
		we <= 0;
		re <= 0;
	endtask
	task automatic rd(input [7:0] a, input s, input [7:0] x, input string n);
		bus(a, s, 0, 8'h00);
		chk(n, x, rdv);
	endtask
	task automatic settle();
		repeat (6) @(negedge clk_in);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run needs about a thousand cycles
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
	// Wake from a change lasts one cycle, so count pulses
	always @(negedge clk_in)
	begin
		if (wake === 1'b1)
			wake_cnt++;
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(31));
		ra = '{`ADDR_LINE_ENABLES, `ADDR_GROUP_ENABLES, `ADDR_SENSE_CONTROL,
			`ADDR_MASK_GROUP0, `ADDR_MASK_GROUP1, `ADDR_MASK_GROUP2};
		rm = '{`LINE_BITS, `GROUP_BITS, `SENSE_BITS, 8'hff, `MASK1_BITS, 8'hff};
		repeat (20) @(negedge clk_in);
		rst_n = 1;
		rd(`ADDR_GROUP_FLAGS, 0, 8'h00, "gflag_rst");
		rd(`ADDR_LINE_FLAGS, 0, 8'h00, "lflag_rst");
		for (i = 0; i < 6; i++)
		begin
			d = $urandom;
			rd(ra[i], 0, 8'h00, "reg_rst");
			bus(ra[i], 0, 1, d);
			rd(ra[i], 0, d & rm[i], "reg_rw");
		end
		rd(8'h50, 0, 8'h00, "unmapped");
		bus(`ADDR_LINE_ENABLES - `IO_OFFSET, 1, 1, 8'h02);
		rd(`ADDR_LINE_ENABLES, 0, 8'h02, "io_alias");
		rd(`ADDR_MASK_GROUP2 - `IO_OFFSET, 1, 8'h00, "io_ext");
		bus(`ADDR_GROUP_ENABLES, 0, 1, 8'h00);
		gie = 1;
		for (l = 0; l < 2; l++)
			for (m = 0; m < 4; m++)
			begin
				bus(`ADDR_SENSE_CONTROL, 0, 1, m << (2 * l));
				bus(`ADDR_LINE_ENABLES, 0, 1, 8'h03);
				lvl[l] = 1;
				settle();
				bus(`ADDR_LINE_FLAGS, 0, 1, 8'h03);
				lvl[l] = 0;
				settle();
				e = hit(m, 1, 0);
				chk("fall_req", e, req[l]);
				chk("wake_lvl", m == 0 || !lvl[1 - l], wake);
				rd(`ADDR_LINE_FLAGS, 0, (e && m != 0) << l, "line_flag");
				gie = 0;
				repeat (2) @(negedge clk_in);
				chk("gie_off", 0, req[l]);
				gie = 1;
				lack[l] = 1;
				@(negedge clk_in);
				lack = 0;
				repeat (2) @(negedge clk_in);
				chk("ack_req", m == 0, req[l]);
				lvl[l] = 1;
				settle();
				chk("rise_req", hit(m, 0, 1), req[l]);
				bus(`ADDR_LINE_FLAGS, 0, 1, 8'h03);
				settle();
				chk("w1c_req", 0, req[l]);
			end
		bus(`ADDR_LINE_ENABLES, 0, 1, 8'h00);
		repeat (30)
		begin
			k = $urandom % 24;
			mk = $urandom;
			ge = $urandom;
			bus(`ADDR_MASK_GROUP0, 0, 1, mk[7:0]);
			bus(`ADDR_MASK_GROUP1, 0, 1, mk[15:8]);
			bus(`ADDR_MASK_GROUP2, 0, 1, mk[23:16]);
			bus(`ADDR_GROUP_ENABLES, 0, 1, ge);
			bus(`ADDR_GROUP_FLAGS, 0, 1, 8'h07);
			wc = wake_cnt;
			lvl[k + 2] = !lvl[k + 2];
			settle();
			ef = (grp(k) < 3 && mk[k] && ge[grp(k)]) ? 3'h1 << grp(k) : 3'h0;
			rd(`ADDR_GROUP_FLAGS, 0, ef, "group_flag");
			chk("group_req", ef, req[4:2]);
			chk("wake_pulse", ef != 0, wake_cnt - wc);
			gack = ef;
			@(negedge clk_in);
			gack = 0;
			repeat (2) @(negedge clk_in);
			chk("group_ack", 0, req[4:2]);
		end
		test_done();
	end
endmodule
`default_nettype wire
